// ==== logic/cst_core.sv ====
// Execution slice: subtract forms, software trap, transfers and test
`timescale 1ns/1ps
`include "cst_defines.svh"
// How it works
// - Subtract literal A0 2cy, short B0 3cy
// - Subtract long address C0, 4 cycles
// - Indexed subtract D0/E0 index plus offset, F0 index only
// - Stack subtract 9EE0/9ED0, stack plus offset
// - Trap 83: pc+1, push five, 9 cycles
// - Trap sets mask, loads vector high low
// - Acc-to-flags 84, flags-to-acc 85
// - Acc/index-low copies 97, 9F, flags kept
// - 95 loads sp+1, 94 loads pair-1
// - Test sets N,Z, clears V
module cst_core (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Memory bus
    output cst_pkg::cst_mem_req_t mem_o,
    input wire logic [7:0] mem_rdata_i,
    // Status
    output cst_pkg::cst_regs_t regs_o,
    output logic busy_o,
    output logic illegal_o
);
    import cst_pkg::*;

    typedef enum logic [6:0] {
        ST_FETCH = 7'h01,
        ST_PRE = 7'h02,
        ST_ARG = 7'h04,
        ST_OPER = 7'h08,
        ST_PUSH = 7'h10,
        ST_VEC = 7'h20,
        ST_WAIT = 7'h40
    } cst_state_t;

    cst_state_t state, next_state;
    cst_regs_t r, next_r;
    cst_dec_t dec, next_dec;
    cst_mem_req_t mem, next_mem;
    logic [15:0] arg, next_arg;
    logic busy, next_busy;
    logic [3:0] cyc, next_cyc;
    logic [2:0] push, next_push;
    logic vec_lo, next_vec_lo;
    logic illegal, next_illegal;
    logic [7:0] alu_res, alu_flags, alu_b;
    logic [15:0] ea;

    // Shared by both opcode pages, so kept as one decoder
    function automatic cst_dec_t decode(input logic pre, input logic [7:0] code);
        cst_dec_t d;
        d = '{op: CST_OP_NONE, am: CST_AM_NONE, code: code, cycles: `CST_CYC_SKIP, arg_bytes: 2'h0};
        if (pre) begin
            case (code)
                `CST_OP_SUB_SPB: d = '{CST_OP_SUB, CST_AM_SPB, code, `CST_CYC_SUB_SPB, 2'h1};
                `CST_OP_SUB_SPW: d = '{CST_OP_SUB, CST_AM_SPW, code, `CST_CYC_SUB_SPW, 2'h2};
                `CST_OP_SZT_SPB: d = '{CST_OP_SZT, CST_AM_SPB, code, `CST_CYC_SZT_SPB, 2'h1};
                default: d.op = CST_OP_NONE;
            endcase
        end else begin
            case (code)
                `CST_OP_SUB_LIT: d = '{CST_OP_SUB, CST_AM_LIT, code, `CST_CYC_SUB_LIT, 2'h1};
                `CST_OP_SUB_SHORT: d = '{CST_OP_SUB, CST_AM_SHORT, code, `CST_CYC_SUB_SHORT, 2'h1};
                `CST_OP_SUB_LONG: d = '{CST_OP_SUB, CST_AM_LONG, code, `CST_CYC_SUB_LONG, 2'h2};
                `CST_OP_SUB_IXW: d = '{CST_OP_SUB, CST_AM_IXW, code, `CST_CYC_SUB_IXW, 2'h2};
                `CST_OP_SUB_IXB: d = '{CST_OP_SUB, CST_AM_IXB, code, `CST_CYC_SUB_IXB, 2'h1};
                `CST_OP_SUB_IX0: d = '{CST_OP_SUB, CST_AM_IX0, code, `CST_CYC_SUB_IX0, 2'h0};
                `CST_OP_TRAP: d = '{CST_OP_TRAP, CST_AM_NONE, code, `CST_CYC_TRAP, 2'h0};
                `CST_OP_A2F: d = '{CST_OP_MOVE, CST_AM_NONE, code, `CST_CYC_A2F, 2'h0};
                `CST_OP_F2A: d = '{CST_OP_MOVE, CST_AM_NONE, code, `CST_CYC_F2A, 2'h0};
                `CST_OP_A2X: d = '{CST_OP_MOVE, CST_AM_NONE, code, `CST_CYC_A2X, 2'h0};
                `CST_OP_X2A: d = '{CST_OP_MOVE, CST_AM_NONE, code, `CST_CYC_X2A, 2'h0};
                `CST_OP_SP2HX: d = '{CST_OP_MOVE, CST_AM_NONE, code, `CST_CYC_SP2HX, 2'h0};
                `CST_OP_HX2SP: d = '{CST_OP_MOVE, CST_AM_NONE, code, `CST_CYC_HX2SP, 2'h0};
                `CST_OP_SZT_SHORT: d = '{CST_OP_SZT, CST_AM_SHORT, code, `CST_CYC_SZT_SHORT, 2'h1};
                `CST_OP_SZT_A: d = '{CST_OP_SZT, CST_AM_NONE, code, `CST_CYC_SZT_A, 2'h0};
                `CST_OP_SZT_X: d = '{CST_OP_SZT, CST_AM_NONE, code, `CST_CYC_SZT_X, 2'h0};
                `CST_OP_SZT_IXB: d = '{CST_OP_SZT, CST_AM_IXB, code, `CST_CYC_SZT_IXB, 2'h1};
                `CST_OP_SZT_IX0: d = '{CST_OP_SZT, CST_AM_IX0, code, `CST_CYC_SZT_IX0, 2'h0};
                default: d.op = CST_OP_NONE;
            endcase
        end
        return d;
    endfunction

    // Effective address for the memory forms
    always_comb begin
        case (dec.am)
            CST_AM_SHORT: ea = {8'h00, arg[7:0]};
            CST_AM_LONG: ea = arg;
            CST_AM_IXW: ea = {r.hi, r.lo} + arg;
            CST_AM_IXB: ea = {r.hi, r.lo} + {8'h00, arg[7:0]};
            CST_AM_IX0: ea = {r.hi, r.lo};
            CST_AM_SPB: ea = r.sp + {8'h00, arg[7:0]};
            CST_AM_SPW: ea = r.sp + arg;
            default: ea = 16'h0000;
        endcase
    end

    // Inherent tests take the register, all others the fetched byte
    always_comb begin
        if (dec.op == CST_OP_SZT && dec.code == `CST_OP_SZT_X && dec.am == CST_AM_NONE) begin
            alu_b = r.lo;
        end else if (dec.op == CST_OP_SZT && dec.am == CST_AM_NONE) begin
            alu_b = r.acc;
        end else if (dec.am == CST_AM_LIT) begin
            alu_b = arg[7:0];
        end else begin
            alu_b = mem_rdata_i;
        end
    end

    cst_alu u_alu (
        .a_i((dec.op == CST_OP_SZT) ? alu_b : r.acc),
        .b_i((dec.op == CST_OP_SZT) ? 8'h00 : alu_b),
        .flags_i(r.flags),
        .test_i(dec.op == CST_OP_SZT),
        .res_o(alu_res),
        .flags_o(alu_flags)
    );

    always_comb begin
        next_state = state;
        next_r = r;
        next_dec = dec;
        next_mem = '0;
        next_arg = arg;
        next_busy = busy;
        next_cyc = (cyc != 4'h0) ? cyc - 4'h1 : 4'h0;
        next_push = push;
        next_vec_lo = vec_lo;
        next_illegal = 1'b0;
        case (state)
            ST_FETCH: begin
                if (cyc <= 4'h1 && !mem.rd) begin
                    next_mem.rd = 1'b1;
                    next_mem.addr = r.pc;
                end else if (mem.rd) begin
                    next_r.pc = r.pc + 16'h0001;
                    next_arg = 16'h0000;
                    if (mem_rdata_i == `CST_OP_PREBYTE) begin
                        next_state = ST_PRE;
                        next_mem.rd = 1'b1;
                        next_mem.addr = r.pc + 16'h0001;
                    end else begin
                        next_dec = decode(1'b0, mem_rdata_i);
                        next_cyc = next_dec.cycles - `CST_CYC_OPCODE;
                        next_state = ST_ARG;
                    end
                end
            end
            ST_PRE: begin
                next_r.pc = r.pc + 16'h0001;
                next_dec = decode(1'b1, mem_rdata_i);
                next_cyc = next_dec.cycles - `CST_CYC_PREFIXED;
                next_state = ST_ARG;
            end
            ST_ARG: begin
                if (dec.op == CST_OP_NONE) begin
                    next_illegal = 1'b1;
                    next_state = ST_FETCH;
                end else if (dec.arg_bytes != 2'h0 && !mem.rd) begin
                    next_mem.rd = 1'b1;
                    next_mem.addr = r.pc;
                end else if (mem.rd) begin
                    // Operand bytes arrive high first
                    next_arg = {arg[7:0], mem_rdata_i};
                    next_r.pc = r.pc + 16'h0001;
                    next_dec.arg_bytes = dec.arg_bytes - 2'h1;
                end else if (dec.am != CST_AM_NONE && dec.am != CST_AM_LIT) begin
                    next_mem.rd = 1'b1;
                    next_mem.addr = ea;
                    next_state = ST_OPER;
                end else begin
                    next_state = ST_OPER;
                end
            end
            ST_OPER: begin
                next_state = ST_WAIT;
                case (dec.op)
                    CST_OP_SUB: begin
                        next_r.acc = alu_res;
                        next_r.flags = alu_flags;
                    end
                    CST_OP_SZT: next_r.flags = alu_flags;
                    CST_OP_TRAP: begin
                        next_push = 3'h0;
                        next_state = ST_PUSH;
                    end
                    CST_OP_MOVE: begin
                        case (dec.code)
                            `CST_OP_A2F: next_r.flags = r.acc;
                            `CST_OP_F2A: next_r.acc = r.flags;
                            `CST_OP_A2X: next_r.lo = r.acc;
                            `CST_OP_X2A: next_r.acc = r.lo;
                            `CST_OP_SP2HX: {next_r.hi, next_r.lo} = r.sp + 16'h0001;
                            `CST_OP_HX2SP: next_r.sp = {r.hi, r.lo} - 16'h0001;
                            default: next_r = r;
                        endcase
                    end
                    default: next_state = ST_FETCH;
                endcase
            end
            ST_PUSH: begin
                // Stored pc already points past the trap opcode
                next_mem.wr = 1'b1;
                next_mem.addr = r.sp;
                case (push)
                    3'h0: next_mem.wdata = r.pc[7:0];
                    3'h1: next_mem.wdata = r.pc[15:8];
                    3'h2: next_mem.wdata = r.lo;
                    3'h3: next_mem.wdata = r.acc;
                    default: next_mem.wdata = r.flags;
                endcase
                next_r.sp = r.sp - 16'h0001;
                next_push = push + 3'h1;
                if (push == `CST_TRAP_PUSHES - 3'h1) begin
                    next_r.flags[`CST_FLAG_I] = 1'b1;
                    next_vec_lo = 1'b0;
                    next_state = ST_VEC;
                end
            end
            ST_VEC: begin
                if (!mem.rd) begin
                    next_mem.rd = 1'b1;
                    next_mem.addr = `CST_TRAP_VECTOR + {15'h0000, vec_lo};
                end else if (!vec_lo) begin
                    next_r.pc[15:8] = mem_rdata_i;
                    next_vec_lo = 1'b1;
                end else begin
                    next_r.pc[7:0] = mem_rdata_i;
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cyc <= 4'h1) begin
                    next_state = ST_FETCH;
                end
            end
            default: next_state = ST_FETCH;
        endcase
        // Registered so the status pin comes straight from a flip-flop
        next_busy = (next_state != ST_FETCH);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_FETCH;
            r <= '{acc: 8'h00, flags: `CST_FLAGS_RESET, hi: 8'h00, lo: 8'h00, sp: `CST_SP_RESET, pc: `CST_PC_RESET};
            dec <= '{op: CST_OP_NONE, am: CST_AM_NONE, code: 8'h00, cycles: 4'h0, arg_bytes: 2'h0};
            mem <= '0;
            arg <= 16'h0000;
            busy <= 1'b0;
            cyc <= 4'h0;
            push <= 3'h0;
            vec_lo <= 1'b0;
            illegal <= 1'b0;
        end else begin
            state <= next_state;
            r <= next_r;
            dec <= next_dec;
            mem <= next_mem;
            arg <= next_arg;
            busy <= next_busy;
            cyc <= next_cyc;
            push <= next_push;
            vec_lo <= next_vec_lo;
            illegal <= next_illegal;
        end
    end

    // Internal pipeline cycles do not match the nominal count exactly
    assign mem_o = mem;
    assign regs_o = r;
    assign busy_o = busy;
    assign illegal_o = illegal;

    sequence s_trap_push;
        state == ST_PUSH && push == 3'h0;
    endsequence
    AST_TRAP_MASK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_trap_push |-> ##5 r.flags[`CST_FLAG_I]) else $error("trap did not set mask");
    AST_TRAP_SP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_trap_push |-> ##5 r.sp == $past(r.sp, 5) - 16'h0005) else $error("trap push count wrong");
    AST_F2A: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state == ST_OPER && dec.code == `CST_OP_F2A && dec.op == CST_OP_MOVE |=> r.acc == $past(r.flags)
        && r.flags == $past(r.flags)) else $error("flags copy wrong");
    AST_X2A: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state == ST_OPER && dec.code == `CST_OP_X2A && dec.op == CST_OP_MOVE |=> r.acc == $past(r.lo)
        && r.hi == $past(r.hi)) else $error("index copy wrong");
    AST_SP2HX: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state == ST_OPER && dec.code == `CST_OP_SP2HX && dec.op == CST_OP_MOVE |=> {r.hi, r.lo} == $past(r.sp)
        + 16'h0001) else $error("stack to pair wrong");
    AST_SZT_V: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state == ST_OPER && dec.op == CST_OP_SZT |=> !r.flags[`CST_FLAG_V]
        && r.flags[`CST_FLAG_C] == $past(r.flags[`CST_FLAG_C])) else $error("test flags wrong");
    AST_SUB_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state == ST_OPER && dec.op == CST_OP_SUB |=> r.flags[`CST_FLAG_H] == $past(r.flags[`CST_FLAG_H])
        && r.flags[`CST_FLAG_I] == $past(r.flags[`CST_FLAG_I])) else $error("subtract touched H or I");
    AST_SUB_IX: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        state == ST_ARG && next_state == ST_OPER && dec.am == CST_AM_IX0 |=> mem.rd
        && mem.addr == {r.hi, r.lo}) else $error("indexed address wrong");
endmodule

// ==== logic/cst_defines.svh ====
// Constants for the subtract, trap, transfer and test execution slice
`ifndef CST_DEFINES_SVH
`define CST_DEFINES_SVH
`define CST_OP_PREBYTE 8'h9E
`define CST_OP_SUB_LIT 8'hA0
`define CST_OP_SUB_SHORT 8'hB0
`define CST_OP_SUB_LONG 8'hC0
`define CST_OP_SUB_IXW 8'hD0
`define CST_OP_SUB_IXB 8'hE0
`define CST_OP_SUB_IX0 8'hF0
`define CST_OP_SUB_SPB 8'hE0
`define CST_OP_SUB_SPW 8'hD0
`define CST_OP_TRAP 8'h83
`define CST_OP_A2F 8'h84
`define CST_OP_F2A 8'h85
`define CST_OP_A2X 8'h97
`define CST_OP_X2A 8'h9F
`define CST_OP_SP2HX 8'h95
`define CST_OP_HX2SP 8'h94
`define CST_OP_SZT_SHORT 8'h3D
`define CST_OP_SZT_A 8'h4D
`define CST_OP_SZT_X 8'h5D
`define CST_OP_SZT_IXB 8'h6D
`define CST_OP_SZT_IX0 8'h7D
`define CST_OP_SZT_SPB 8'h6D
`define CST_FLAG_C 0
`define CST_FLAG_Z 1
`define CST_FLAG_N 2
`define CST_FLAG_I 3
`define CST_FLAG_H 4
`define CST_FLAG_V 7
`define CST_FLAGS_RESET 8'h68
`define CST_SP_RESET 16'h00FF
`define CST_PC_RESET 16'h0000
`define CST_TRAP_VECTOR 16'hFFFC
`define CST_TRAP_PUSHES 3'h5
`define CST_CYC_TRAP 4'h9
`define CST_CYC_SKIP 4'h1
`define CST_CYC_OPCODE 4'h1
`define CST_CYC_PREFIXED 4'h2
`define CST_CYC_SUB_LIT 4'h2
`define CST_CYC_SUB_SHORT 4'h3
`define CST_CYC_SUB_LONG 4'h4
`define CST_CYC_SUB_IXW 4'h4
`define CST_CYC_SUB_IXB 4'h3
`define CST_CYC_SUB_IX0 4'h2
`define CST_CYC_SUB_SPB 4'h4
`define CST_CYC_SUB_SPW 4'h5
`define CST_CYC_A2F 4'h2
`define CST_CYC_F2A 4'h1
`define CST_CYC_A2X 4'h1
`define CST_CYC_X2A 4'h1
`define CST_CYC_SP2HX 4'h2
`define CST_CYC_HX2SP 4'h2
`define CST_CYC_SZT_SHORT 4'h3
`define CST_CYC_SZT_A 4'h1
`define CST_CYC_SZT_X 4'h1
`define CST_CYC_SZT_IXB 4'h3
`define CST_CYC_SZT_IX0 4'h2
`define CST_CYC_SZT_SPB 4'h4
`endif

// ==== logic/cst_pkg.sv ====
// Types for the subtract, trap, transfer and test execution slice
package cst_pkg;
    // Memory request toward the system bus
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cst_mem_req_t;
    // Visible programmer state
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [15:0] sp;
        logic [15:0] pc;
    } cst_regs_t;
    typedef enum logic [3:0] {
        CST_OP_NONE = 4'h0,
        CST_OP_SUB = 4'h1,
        CST_OP_SZT = 4'h2,
        CST_OP_TRAP = 4'h3,
        CST_OP_MOVE = 4'h4
    } cst_op_t;
    typedef enum logic [3:0] {
        CST_AM_NONE = 4'h0,
        CST_AM_LIT = 4'h1,
        CST_AM_SHORT = 4'h2,
        CST_AM_LONG = 4'h3,
        CST_AM_IXW = 4'h4,
        CST_AM_IXB = 4'h5,
        CST_AM_IX0 = 4'h6,
        CST_AM_SPB = 4'h7,
        CST_AM_SPW = 4'h8
    } cst_am_t;
    typedef struct packed {
        cst_op_t op;
        cst_am_t am;
        logic [7:0] code;
        logic [3:0] cycles;
        logic [1:0] arg_bytes;
    } cst_dec_t;
endpackage

// ==== logic/cst_alu.sv ====
// Subtract and sign/zero test datapath with flag update
`timescale 1ns/1ps
`include "cst_defines.svh"
module cst_alu (
    // Operands
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic [7:0] flags_i,
    input wire logic test_i,
    // Result
    output logic [7:0] res_o,
    output logic [7:0] flags_o
);
    logic [8:0] diff;
    always_comb begin
        diff = {1'b0, a_i} - {1'b0, b_i};
        res_o = diff[7:0];
        flags_o = flags_i;
        flags_o[`CST_FLAG_N] = diff[7];
        flags_o[`CST_FLAG_Z] = (diff[7:0] == 8'h00);
        if (test_i) begin
            flags_o[`CST_FLAG_V] = 1'b0;
        end else begin
            flags_o[`CST_FLAG_V] = (a_i[7] & ~b_i[7] & ~diff[7]) | (~a_i[7] & b_i[7] & diff[7]);
            flags_o[`CST_FLAG_C] = diff[8];
        end
    end
endmodule

// ==== test/cst_mem_model.sv ====
// Behavioural memory on the far side of the core's bus
`timescale 1ns/1ps
module cst_mem_model
    import cst_pkg::*;
(
    // Clock
    input wire logic mclk_i,
    // Bus from the core
    input wire cst_pkg::cst_mem_req_t mem_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] idle = 8'h5A;

    // Data stands while rd is high; the core takes it at the edge that ends rd
    // An idle bus keeps changing so a late sample shows up as a mismatch
    always @(posedge mclk_i) begin
        idle <= ~idle;
        if (mem_i.wr) begin
            mem[mem_i.addr] <= mem_i.wdata;
        end
    end
    assign rdata_o = mem_i.rd ? mem[mem_i.addr] : idle;
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the execution slice
`timescale 1ns/1ps
`include "cst_defines.svh"
module tb;
    import cst_pkg::*;
    logic mclk_i;
    logic rst_n_i = 1'b0;
    cst_mem_req_t mem_o;
    logic [7:0] mem_rdata_i;
    cst_regs_t regs_o;
    logic busy_o;
    logic illegal_o;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int ill_exp = 0;
    logic [7:0] img [0:65535];
    cst_regs_t st;
    logic [15:0] at;
    cst_regs_t exp_q [$];
    logic [23:0] wr_q [$];
    logic prev_busy = 1'b0;

    cst_core dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
        .regs_o(regs_o), .busy_o(busy_o), .illegal_o(illegal_o));
    cst_mem_model mem_u (.mclk_i(mclk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic stop_test();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic report(input string msg);
        num_errors++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    // Whole run needs a few hundred cycles
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            report("timeout");
            stop_test();
        end
    end

    // Results appear when busy drops; pushes appear as write pulses
    always @(negedge mclk_i) begin
        cst_regs_t e;
        logic [23:0] w;
        if (rst_n_i === 1'b1 && exp_q.size() > 0) begin
            if (illegal_o === 1'b1 && ill_exp > 0) begin
                ill_exp--;
                total_checks++;
            end else if (illegal_o !== 1'b0) begin
                report("unexpected illegal pulse");
            end
            if (mem_o.wr === 1'b1) begin
                w = (wr_q.size() > 0) ? wr_q.pop_front() : 24'h000000;
                total_checks++;
                if ({mem_o.addr, mem_o.wdata} !== w) report($sformatf("push %h exp %h", mem_o, w));
            end
            if (prev_busy === 1'b1 && busy_o === 1'b0) begin
                e = exp_q.pop_front();
                total_checks++;
                if (regs_o !== e) report($sformatf("regs %h exp %h", regs_o, e));
            end
        end
        prev_busy = busy_o;
    end

    task automatic emit(input logic [7:0] b);
        img[at] = b;
        at = at + 16'h0001;
    endtask

    // Lays down one instruction and notes its expected outcome
    task automatic op(input logic [7:0] pre, input logic [7:0] opc, input int n, input logic [15:0] arg);
        logic [15:0] ix;
        logic [15:0] ea;
        logic [7:0] m;
        logic [7:0] r;
        logic [7:0] pv [5];
        ix = {st.hi, st.lo};
        if (pre != 8'h00) emit(pre);
        emit(opc);
        if (n == 2) emit(arg[15:8]);
        if (n > 0) emit(arg[7:0]);
        st.pc = at;
        case (opc[7:4])
            4'h3, 4'hB: ea = {8'h00, arg[7:0]};
            4'hC: ea = arg;
            4'h7, 4'hF: ea = ix;
            default: ea = (pre != 8'h00) ? st.sp + arg : ix + arg;
        endcase
        m = img[ea];
        if (opc == 8'hA0) m = arg[7:0];
        if (opc == 8'h4D) m = st.acc;
        if (opc == 8'h5D) m = st.lo;
        if (opc[3:0] == 4'h0 || opc[3:0] == 4'hD) begin
            r = (opc[3:0] == 4'h0) ? st.acc - m : m;
            st.flags[`CST_FLAG_V] = (opc[3:0] == 4'h0) && (st.acc[7] != m[7]) && (r[7] == m[7]);
            st.flags[`CST_FLAG_N] = r[7];
            st.flags[`CST_FLAG_Z] = (r == 8'h00);
            if (opc[3:0] == 4'h0) begin
                st.flags[`CST_FLAG_C] = (m > st.acc);
                st.acc = r;
            end
        end
        case (opc)
            8'h84: st.flags = st.acc;
            8'h85: st.acc = st.flags;
            8'h97: st.lo = st.acc;
            8'h9F: st.acc = st.lo;
            8'h95: {st.hi, st.lo} = st.sp + 16'h0001;
            8'h94: st.sp = ix - 16'h0001;
            8'h83: begin
                pv = '{st.pc[7:0], st.pc[15:8], st.lo, st.acc, st.flags};
                for (int i = 0; i < 5; i++) wr_q.push_back({st.sp - 16'(i), pv[i]});
                st.sp = st.sp - 16'h0005;
                st.flags[`CST_FLAG_I] = 1'b1;
                st.pc = {img[16'hFFFC], img[16'hFFFD]};
                at = st.pc;
            end
            default: ;
        endcase
        exp_q.push_back(st);
    endtask

    task automatic set_acc(input logic [7:0] v);
        op(8'h00, 8'hA0, 1, {8'h00, st.acc - v});
    endtask

    // Opcode outside the slice: pulse expected, only its own byte skipped
    task automatic bad(input logic [7:0] opc);
        emit(opc);
        st.pc = at;
        ill_exp++;
        exp_q.push_back(st);
    endtask

    task automatic begin_test();
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        exp_q.delete();
        wr_q.delete();
        ill_exp = 0;
        at = 16'h0000;
        st = '{acc: 8'h00, flags: 8'h68, hi: 8'h00, lo: 8'h00, sp: 16'h00FF, pc: 16'h0000};
        // Unused space holds a harmless opcode of this slice
        foreach (img[i]) img[i] = 8'h4D;
        for (int i = 16'h0080; i < 16'h0400; i++) img[i] = 8'($urandom);
        img[16'hFFFC] = 8'h02;
        img[16'hFFFD] = 8'h00;
    endtask

    task automatic run(input string name);
        mem_u.mem = img;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (4000) begin
            if (exp_q.size() == 0) break;
            @(posedge mclk_i);
        end
        if (exp_q.size() != 0 || wr_q.size() != 0 || ill_exp != 0) report("results missing");
        $display("Test %s done", name);
    endtask

    initial begin
        void'($urandom(32'h1540190f));
        begin_test();
        op(8'h00, 8'hA0, 1, 16'($urandom % 256));
        set_acc(8'h00);
        op(8'h00, 8'hA0, 1, 16'h0080);
        op(8'h00, 8'hB0, 1, 16'h0080);
        op(8'h00, 8'hC0, 2, 16'h0300);
        op(8'h00, 8'h95, 0, 16'h0000);
        op(8'h00, 8'hD0, 2, 16'h0210);
        op(8'h00, 8'hE0, 1, 16'h0020);
        op(8'h00, 8'hF0, 0, 16'h0000);
        op(8'h9E, 8'hE0, 1, 16'h0010);
        op(8'h9E, 8'hD0, 2, 16'h0201);
        run("subtract");
        begin_test();
        set_acc(8'($urandom));
        op(8'h00, 8'h97, 0, 16'h0000);
        set_acc(8'($urandom));
        op(8'h00, 8'h9F, 0, 16'h0000);
        set_acc(8'($urandom) | 8'h60);
        op(8'h00, 8'h84, 0, 16'h0000);
        set_acc(8'h00);
        op(8'h00, 8'h85, 0, 16'h0000);
        op(8'h00, 8'h95, 0, 16'h0000);
        op(8'h00, 8'h94, 0, 16'h0000);
        set_acc(8'($urandom));
        op(8'h00, 8'h97, 0, 16'h0000);
        op(8'h00, 8'h94, 0, 16'h0000);
        op(8'h00, 8'h95, 0, 16'h0000);
        bad(8'h81);
        run("transfer");
        begin_test();
        set_acc(8'h80);
        op(8'h00, 8'h4D, 0, 16'h0000);
        set_acc(8'h00);
        op(8'h00, 8'h4D, 0, 16'h0000);
        op(8'h00, 8'h3D, 1, 16'h0090);
        set_acc(8'($urandom));
        op(8'h00, 8'h97, 0, 16'h0000);
        op(8'h00, 8'h5D, 0, 16'h0000);
        op(8'h00, 8'h95, 0, 16'h0000);
        op(8'h00, 8'h6D, 1, 16'h0030);
        op(8'h00, 8'h7D, 0, 16'h0000);
        op(8'h9E, 8'h6D, 1, 16'h0005);
        run("test");
        begin_test();
        set_acc(8'h60);
        op(8'h00, 8'h84, 0, 16'h0000);
        set_acc(8'($urandom));
        op(8'h00, 8'h97, 0, 16'h0000);
        op(8'h00, 8'h83, 0, 16'h0000);
        op(8'h00, 8'h85, 0, 16'h0000);
        op(8'h00, 8'hA0, 1, 16'($urandom % 256));
        run("trap");
        stop_test();
    end
endmodule
